// file: psers_pkg.sv
package psers_pkg;

   // ****************************************
   // Device power states
   // ****************************************
   typedef enum logic [2:0] {
      PSERS_FULL_OFF,
      PSERS_CORE_OFF,
      PSERS_HARD_RESET,
      PSERS_DEFAULT,
      PSERS_DOZE,
      PSERS_RECEIVE,
      PSERS_TRANSMIT,
      PSERS_IDLE_CONNECT
   } psers_state_type;

   // ****************************************
   // Activity requests from firmware side
   // ****************************************
   typedef enum logic [1:0] {
      PSERS_REQ_DOZE,
      PSERS_REQ_RECEIVE,
      PSERS_REQ_TRANSMIT,
      PSERS_REQ_IDLE
   } psers_req_type;

   // ****************************************
   // Pad control bundle, one bit per pad
   // ****************************************
   localparam int PSERS_NPADS = 8;

   typedef struct packed {
      logic [PSERS_NPADS-1:0] out_en;
      logic [PSERS_NPADS-1:0] in_en;
      logic [PSERS_NPADS-1:0] pull_en;
   } psers_pad_type;

   // ****************************************
   // Timing figures
   // ****************************************
   localparam int PSERS_CLK_MHZ = 100;
   localparam int PSERS_XO_SETTLE_MS = 5;
   localparam int PSERS_RESET_PULSE_US = 1;
   localparam int PSERS_XO_SETTLE_CYC = PSERS_XO_SETTLE_MS * 1000 * PSERS_CLK_MHZ;
   localparam int PSERS_RESET_PULSE_CYC = PSERS_RESET_PULSE_US * PSERS_CLK_MHZ;
   localparam int PSERS_DTIM_CYC = 102400;

   localparam logic [PSERS_NPADS-1:0] PSERS_PADS_ALL = {PSERS_NPADS{1'b1}};
   localparam logic [PSERS_NPADS-1:0] PSERS_PADS_NONE = {PSERS_NPADS{1'b0}};

endpackage : psers_pkg

// file: psers_sequencer.sv
// What this block does
// R1: Transmit state drives the radio transmitter at highest output power.
// R2: Receive state keeps the core supply on and the receiver running.
// R3: Doze keeps power on with neither transmitter nor receiver active.
// R4: Idle-connect stays associated and wakes once per beacon interval.
// R5: Core-off switches the core supply off.
// R6: Chip-enable high turns the converter on; low turns it off.
// R7: Host holds chip-enable high with I/O supply for any active state.
// R8: Host moves between active and core-off by driving chip-enable.
// R9: I/O supply off and chip-enable low means fully powered off.
// R10: Host never raises chip-enable before the I/O supply rises.
// R11: Host always drives chip-enable and reset, never floating.
// R12: Host waits 5 ms after chip-enable before releasing reset; with early_i the host model releases early.
// R13: On power-down chip-enable falls no later than the I/O supply.
// R14: On power-down reset asserts no later than the I/O supply falls.
// R15: Chip-enable fall and reset assertion may coincide.
// R16: Pads: core-off all off; hard reset pulls; default inputs and pulls.
// R17: Programmed states take firmware pad settings, input opposite output.
// R18: Host pulses reset low at least 1 us to reset the device.
// R19: Host keeps reset asserted for as long as chip-enable is low; the counter only runs after chip-enable rises.
// R20: Rising edge of reset moves hard reset to the default state.
`timescale 1ns/1ps
module psers_sequencer #(
   parameter int XO_SETTLE_CYC = psers_pkg::PSERS_XO_SETTLE_CYC,
   parameter int DTIM_CYC = psers_pkg::PSERS_DTIM_CYC
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic io_supply_i,
   input wire logic chip_enable_i,
   input wire logic hard_reset_low_pin_i,
   input wire logic fw_ready_i,
   input wire psers_pkg::psers_req_type fw_req_i,
   input wire logic [psers_pkg::PSERS_NPADS-1:0] fw_out_en_i,
   input wire logic [psers_pkg::PSERS_NPADS-1:0] fw_pull_en_i,
   output psers_pkg::psers_state_type state_o,
   output logic dcdc_on_o,
   output logic core_rstn_o,
   output logic tx_en_o,
   output logic tx_max_power_o,
   output logic rx_en_o,
   output logic beacon_wake_o,
   output logic seq_violation_o,
   output psers_pkg::psers_pad_type pad_o
);
   import psers_pkg::*;

   // ****************************************
   // Pin synchronisers, three stages each
   // ****************************************
   logic [2:0] io_sync_r;
   logic [2:0] ce_sync_r;
   logic [2:0] rst_sync_r;
   logic io_r;
   logic ce_r;
   logic rstn_pin_r;

   // Shift pins in
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
      begin
         io_sync_r <= 3'h0;
         ce_sync_r <= 3'h0;
         rst_sync_r <= 3'h0;
      end
      else
      begin
         io_sync_r <= {io_sync_r[1:0], io_supply_i};
         ce_sync_r <= {ce_sync_r[1:0], chip_enable_i};
         rst_sync_r <= {rst_sync_r[1:0], hard_reset_low_pin_i};
      end

   // Accept a change once stages two and three agree
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
      begin
         io_r <= 1'b0;
         ce_r <= 1'b0;
         rstn_pin_r <= 1'b0;
      end
      else
      begin
         if (io_sync_r[1] == io_sync_r[2])
            io_r <= io_sync_r[2];
         if (ce_sync_r[1] == ce_sync_r[2])
            ce_r <= ce_sync_r[2];
         if (rst_sync_r[1] == rst_sync_r[2])
            rstn_pin_r <= rst_sync_r[2];
      end

   // ****************************************
   // Host sequencing monitor
   // ****************************************
   logic [$clog2(XO_SETTLE_CYC+1)-1:0] settle_cnt_r;
   logic rstn_pin_d_r;
   logic viol_r;
   wire rst_rise = rstn_pin_r && !rstn_pin_d_r;

   // Count cycles since chip-enable went high
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         settle_cnt_r <= '0;
      else if (!ce_r)
         settle_cnt_r <= '0;
      else if (settle_cnt_r != ($bits(settle_cnt_r))'(XO_SETTLE_CYC))
         settle_cnt_r <= settle_cnt_r + 1'b1;

   // Sticky flag for host ordering faults
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
      begin
         rstn_pin_d_r <= 1'b0;
         viol_r <= 1'b0;
      end
      else
      begin
         rstn_pin_d_r <= rstn_pin_r;
         // R10: enable before supply
         if (ce_r && !io_r)
            viol_r <= 1'b1;
         // R12: early reset release
         if (rst_rise && settle_cnt_r != ($bits(settle_cnt_r))'(XO_SETTLE_CYC))
            viol_r <= 1'b1;
      end
   assign seq_violation_o = viol_r;

   // ****************************************
   // Power state machine
   // ****************************************
   psers_state_type state_r;
   psers_state_type state_nxt;

   // Next state from pins and firmware request
   always_comb
   begin
      state_nxt = state_r;
      // R9: no supply and no enable
      if (!io_r && !ce_r)
         state_nxt = PSERS_FULL_OFF;
      // R5: enable low means core off
      else if (!ce_r)
         state_nxt = PSERS_CORE_OFF;
      else if (!rstn_pin_r)
         state_nxt = PSERS_HARD_RESET;
      else
         case (state_r)
            PSERS_FULL_OFF, PSERS_CORE_OFF: state_nxt = PSERS_HARD_RESET;
            // R20: release leaves hard reset; the pin is high on this path, so a
            // release that came while enable was low cannot strand the state here
            PSERS_HARD_RESET: state_nxt = PSERS_DEFAULT;
            PSERS_DEFAULT, PSERS_DOZE, PSERS_RECEIVE, PSERS_TRANSMIT, PSERS_IDLE_CONNECT:
               if (fw_ready_i)
                  case (fw_req_i)
                     PSERS_REQ_RECEIVE: state_nxt = PSERS_RECEIVE;
                     PSERS_REQ_TRANSMIT: state_nxt = PSERS_TRANSMIT;
                     PSERS_REQ_IDLE: state_nxt = PSERS_IDLE_CONNECT;
                     default: state_nxt = PSERS_DOZE;
                  endcase
            default: state_nxt = PSERS_HARD_RESET;
         endcase
   end

   // State register
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         state_r <= PSERS_FULL_OFF;
      else
         state_r <= state_nxt;
   assign state_o = state_r;

   // ****************************************
   // Beacon interval timer for idle-connect
   // ****************************************
   logic [$clog2(DTIM_CYC)-1:0] dtim_cnt_r;
   logic wake_r;

   // R4: one wake per interval
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
      begin
         dtim_cnt_r <= '0;
         wake_r <= 1'b0;
      end
      else if (state_r != PSERS_IDLE_CONNECT)
      begin
         dtim_cnt_r <= '0;
         wake_r <= 1'b0;
      end
      else
      begin
         wake_r <= (dtim_cnt_r == ($bits(dtim_cnt_r))'(DTIM_CYC - 1));
         if (dtim_cnt_r == ($bits(dtim_cnt_r))'(DTIM_CYC - 1))
            dtim_cnt_r <= '0;
         else
            dtim_cnt_r <= dtim_cnt_r + 1'b1;
      end
   assign beacon_wake_o = wake_r;

   // ****************************************
   // Power, radio and pad outputs
   // ****************************************
   logic dcdc_r;
   logic core_rstn_r;
   logic tx_r;
   logic rx_r;
   psers_pad_type pad_r;

   // R6: converter follows enable
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
      begin
         dcdc_r <= 1'b0;
         core_rstn_r <= 1'b0;
      end
      else
      begin
         dcdc_r <= ce_r;
         core_rstn_r <= ce_r && rstn_pin_r;
      end

   // R1: R2: R3: radio enables per state
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
      begin
         tx_r <= 1'b0;
         rx_r <= 1'b0;
      end
      else
      begin
         tx_r <= (state_nxt == PSERS_TRANSMIT);
         rx_r <= (state_nxt == PSERS_RECEIVE);
      end

   // R16: R17: pad control table
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         pad_r <= '{PSERS_PADS_NONE, PSERS_PADS_NONE, PSERS_PADS_NONE};
      else
         case (state_nxt)
            PSERS_HARD_RESET: pad_r <= '{PSERS_PADS_NONE, PSERS_PADS_NONE, PSERS_PADS_ALL};
            PSERS_DEFAULT: pad_r <= '{PSERS_PADS_NONE, PSERS_PADS_ALL, PSERS_PADS_ALL};
            PSERS_DOZE, PSERS_RECEIVE, PSERS_TRANSMIT, PSERS_IDLE_CONNECT:
               pad_r <= '{fw_out_en_i, ~fw_out_en_i, fw_pull_en_i};
            default: pad_r <= '{PSERS_PADS_NONE, PSERS_PADS_NONE, PSERS_PADS_NONE};
         endcase

   assign dcdc_on_o = dcdc_r;
   assign core_rstn_o = core_rstn_r;
   assign tx_en_o = tx_r;
   assign tx_max_power_o = tx_r;
   assign rx_en_o = rx_r;
   assign pad_o = pad_r;

   // ****************************************
   // Checks
   // ****************************************
   // R1: transmit only in transmit
   AST_TX_ONLY_IN_TX: assert property (@(posedge clk_i) disable iff (!rstn_i) // R1
      tx_en_o |-> state_o == PSERS_TRANSMIT) else $error("tx on outside transmit");
   // R2: receive with core on
   AST_RX_ONLY_IN_RX: assert property (@(posedge clk_i) disable iff (!rstn_i) // R2
      rx_en_o |-> state_o == PSERS_RECEIVE && dcdc_on_o) else $error("rx bad");
   // R3: doze radio quiet
   AST_DOZE_QUIET: assert property (@(posedge clk_i) disable iff (!rstn_i) // R3
      state_o == PSERS_DOZE |-> !tx_en_o && !rx_en_o) else $error("doze radio on");
   // R4: wake only idle-connect
   AST_NO_WAKE_OUTSIDE_IDLE: assert property (@(posedge clk_i) disable iff (!rstn_i) // R4
      beacon_wake_o |-> $past(state_o) == PSERS_IDLE_CONNECT) else $error("stray wake");
   // R5: core off converter
   AST_CORE_OFF_DCDC: assert property (@(posedge clk_i) disable iff (!rstn_i) // R5
      !ce_r ##1 !ce_r |-> !dcdc_on_o) else $error("converter on w/o enable");
   // R6: converter follows enable
   AST_DCDC_FOLLOWS: assert property (@(posedge clk_i) disable iff (!rstn_i) // R6
      ce_r |=> dcdc_on_o) else $error("converter not on");
   // R9: fully off state
   AST_FULL_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i) // R9
      !io_r && !ce_r |=> state_o == PSERS_FULL_OFF) else $error("not fully off");
   // R16: core off pads
   AST_PADS_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i) // R16
      state_o == PSERS_CORE_OFF |-> pad_o == '0) else $error("pads live in core off");
   // R17: input opposite output
   AST_PAD_OPPOSITE: assert property (@(posedge clk_i) disable iff (!rstn_i) // R17
      state_o == PSERS_DOZE |-> pad_o.in_en == ~pad_o.out_en) else $error("pad dir");
   // R20: release to default
   AST_RESET_RELEASE: assert property (@(posedge clk_i) disable iff (!rstn_i) // R20
      state_o == PSERS_HARD_RESET && rst_rise && ce_r |=> state_o == PSERS_DEFAULT)
      else $error("release missed");

endmodule : psers_sequencer

// file: psers_host_model.sv
`timescale 1ns/1ps
module psers_host_model #(
   parameter int SETTLE_CYC = 50,
   parameter int PULSE_CYC = 100
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic power_req_i,
   input wire logic early_i,
   input wire logic pulse_i,
   output logic io_supply_o,
   output logic chip_enable_o,
   output logic hard_reset_low_pin_o
);
   // ****************************************
   // Host pin sequencing
   // ****************************************
   logic [15:0] cnt_r;

   // Supply first, then enable, then a timed reset release; early_i cuts the wait short
   // ordered pin drive
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         io_supply_o <= 1'b0;
         chip_enable_o <= 1'b0;
         hard_reset_low_pin_o <= 1'b0;
         cnt_r <= 16'h0;
      end
      else if (!power_req_i)
      begin
         chip_enable_o <= 1'b0;
         hard_reset_low_pin_o <= 1'b0;
         io_supply_o <= chip_enable_o; // Supply drops one cycle after enable
      end
      else if (!io_supply_o)
         io_supply_o <= 1'b1;
      else if (!chip_enable_o)
      begin
         chip_enable_o <= 1'b1;
         cnt_r <= 16'h0;
      end
      else if (pulse_i && hard_reset_low_pin_o)
      begin
         hard_reset_low_pin_o <= 1'b0;
         cnt_r <= 16'h0;
      end
      else if (!hard_reset_low_pin_o)
      begin
         cnt_r <= cnt_r + 16'h1;
         if (int'(cnt_r) >= (early_i ? SETTLE_CYC / 2 : SETTLE_CYC + PULSE_CYC))
            hard_reset_low_pin_o <= 1'b1;
      end
   end
endmodule : psers_host_model

// file: tb.sv
`timescale 1ns/1ps
module tb;
   import psers_pkg::*;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic clk_i, rstn_i, power_req, early, pulse, io_supply, chip_en, reset_pin, fw_ready;
   psers_req_type fw_req;
   logic [7:0] fw_out, fw_pull;
   psers_state_type state;
   logic dcdc, core_rstn, tx_en, tx_max, rx_en, beacon, viol;
   psers_pad_type pad;
   int n_mismatch = 0;
   int checked = 0;
   wire logic [23:0] st = {18'h0, dcdc, core_rstn, tx_en, tx_max, rx_en, viol};
   psers_sequencer #(.XO_SETTLE_CYC(50), .DTIM_CYC(16)) i_psers_sequencer (.clk_i(clk_i),
      .rstn_i(rstn_i), .io_supply_i(io_supply), .chip_enable_i(chip_en),
      .hard_reset_low_pin_i(reset_pin), .fw_ready_i(fw_ready), .fw_req_i(fw_req),
      .fw_out_en_i(fw_out), .fw_pull_en_i(fw_pull), .state_o(state), .dcdc_on_o(dcdc),
      .core_rstn_o(core_rstn), .tx_en_o(tx_en), .tx_max_power_o(tx_max), .rx_en_o(rx_en),
      .beacon_wake_o(beacon), .seq_violation_o(viol), .pad_o(pad));
   psers_host_model #(.SETTLE_CYC(50), .PULSE_CYC(100)) i_psers_host_model (.clk_i(clk_i),
      .rstn_i(rstn_i), .power_req_i(power_req), .early_i(early), .pulse_i(pulse),
      .io_supply_o(io_supply), .chip_enable_o(chip_en), .hard_reset_low_pin_o(reset_pin));

   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Polls at falling edges, bounded, until the state shows up
   task automatic wait_st(input psers_state_type s);
      for (int i = 0; i < 400 && state !== s; i++)
         @(negedge clk_i);
      chk(24'(state), 24'(s));
   endtask : wait_st

   task automatic wrap_up;
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_power_up(input logic e);
      early = e;
      power_req = 1'b1;
      wait_st(PSERS_HARD_RESET);
      chk(st, 24'h20);
      chk(pad, {PSERS_PADS_NONE, PSERS_PADS_NONE, PSERS_PADS_ALL});
      wait_st(PSERS_DEFAULT);
      repeat (8) @(negedge clk_i);
      chk(24'(state), 24'(PSERS_DEFAULT));
      chk(st, e ? 24'h31 : 24'h30);
      chk(pad, {PSERS_PADS_NONE, PSERS_PADS_ALL, PSERS_PADS_ALL});
   endtask : t_power_up

   task automatic t_active;
      psers_state_type exp_s[4] = '{PSERS_DOZE, PSERS_RECEIVE, PSERS_TRANSMIT, PSERS_IDLE_CONNECT};
      logic [23:0] exp_v[4] = '{24'h30, 24'h32, 24'h3c, 24'h30};
      int n;
      fw_ready = 1'b1;
      for (int r = 0; r < 4; r++)
      begin
         fw_req = psers_req_type'(r);
         wait_st(exp_s[r]);
         chk(st, exp_v[r]);
         chk(pad, {fw_out, ~fw_out, fw_pull});
      end
      n = 0;
      repeat (48)
      begin
         @(negedge clk_i);
         n += int'(beacon);
      end
      chk(24'(n), 24'd3);
   endtask : t_active

   task automatic t_pulse;
      fw_ready = 1'b0;
      pulse = 1'b1;
      @(negedge clk_i);
      pulse = 1'b0;
      wait_st(PSERS_HARD_RESET);
      chk(pad, {PSERS_PADS_NONE, PSERS_PADS_NONE, PSERS_PADS_ALL});
      wait_st(PSERS_DEFAULT);
      chk(st, 24'h30);
   endtask : t_pulse

   task automatic t_power_down(input logic v);
      power_req = 1'b0;
      wait_st(PSERS_CORE_OFF);
      chk(st, 24'(v));
      chk(pad, 24'h0);
      wait_st(PSERS_FULL_OFF);
   endtask : t_power_down

   // ****************************************
   // Clock, sequence and watchdog
   // ****************************************
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   initial
   begin
      {rstn_i, power_req, early, pulse, fw_ready} = 5'h0;
      fw_req = PSERS_REQ_TRANSMIT;
      fw_out = 8'ha5;
      fw_pull = 8'h3c;
      repeat (3) @(negedge clk_i);
      rstn_i = 1'b1;
      chk(24'(state), 24'(PSERS_FULL_OFF));
      t_power_up(1'b0);
      t_active;
      t_pulse;
      t_power_down(1'b0);
      t_power_up(1'b1);
      t_power_down(1'b1);
      wrap_up;
   end

   initial
   begin
      #100000;
      n_mismatch++;
      wrap_up;
   end
endmodule : tb
